/* hw/pabc_pkg.sv */
// pabc_pkg: register map, field layout and reset values for the two-port pin control block.
// assumes a 32-bit APB bus with byte addresses; each register takes one aligned word.
package pabc_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_A_DIR    = 8'h00; // write: first port direction, read: pin levels
	localparam logic [7:0] OFS_A_LATCH  = 8'h04; // first_port_output_latch
	localparam logic [7:0] OFS_B_DIR    = 8'h08; // write: second_port_direction, read: pin levels
	localparam logic [7:0] OFS_B_LATCH  = 8'h0C; // second_port_output_latch
	localparam logic [7:0] OFS_MODE     = 8'h10; // operating mode and address-width signals
	localparam logic [7:0] OFS_PERIPH   = 8'h14; // serial, keyboard mask and event select bits
	localparam logic [7:0] OFS_STATUS   = 8'h18; // pull-up and drive state, read only

	// register index used by the decoder
	typedef enum logic [2:0] {
		REG_A_DIR    = 3'h0,
		REG_A_LATCH  = 3'h1,
		REG_B_DIR    = 3'h2,
		REG_B_LATCH  = 3'h3,
		REG_MODE     = 3'h4,
		REG_PERIPH   = 3'h5,
		REG_STATUS   = 3'h6,
		REG_NONE     = 3'h7
	} pabc_reg_t;

	// operating mode, one-hot
	typedef enum logic [2:0] {
		MODE_SINGLE  = 3'b001,
		MODE_MUX     = 3'b010,
		MODE_NORMAL  = 3'b100
	} pabc_mode_t;

	// mode register fields
	localparam int MODE_LSB      = 0;
	localparam int MODE_W        = 3;
	localparam int ADDR13_BIT    = 3;
	localparam int ADDR18_BIT    = 4;
	localparam logic [31:0] MODE_RESET = 32'h0000_0019; // single-chip, no address pins

	// peripheral register fields
	localparam int S0_EXT_BIT    = 0;
	localparam int S0_SYNC_BIT   = 1;
	localparam int S0_CLKIN_BIT  = 2;
	localparam int S2_EXT_BIT    = 3;
	localparam int S2_SYNC_BIT   = 4;
	localparam int S2_CLKIN_BIT  = 5;
	localparam int KMASK_LSB     = 8;
	localparam int EVSEL_LSB     = 16;
	localparam int EVSEL_W       = 4;
	localparam logic [31:0] PERIPH_RESET = 32'h0000_FF00; // all keyboard inputs masked

	// status register fields
	localparam int STAT_PU_LSB   = 0;
	localparam int STAT_AOE_LSB  = 8;
	localparam int STAT_BOE_LSB  = 16;

	// port widths and reset values
	localparam int PORT_W        = 8;
	localparam logic [7:0] PORT_RESET = 8'h00;
	localparam int ADDR_PIN_BASE = 16; // first port pin n carries address bit 16+n

endpackage : pabc_pkg

/* hw/pabc_pins.sv */
// pabc_pins: pin control for two 8-bit general-purpose ports behind an APB slave.
// assumes pins are resolved outside from out/oe; bus_address_high and standby
// inputs come from logic on pclk.
//
// Behaviour
// - normal extended pin0: serial clock in, else input, output, or address bit 16.
// - pins 7..0 feed keyboard wakeup when mask is 0; software keeps direction 0.
// - event-selected pin still drives its output when its direction bit is 1.
// - single-chip and multiplexed modes: pins 7..2 never output address bits.
// - pin1 is second serial clock input when its three enable bits are 1.
// - pin0 is first serial clock input when its three enable bits are 1.
// - first port pull-up on only when direction 0 and output latch 1.
// - all first port pull-ups off during reset and hardware standby.
// - software standby keeps each pull-up in its prior state.
// - second port direction write-only, 1 output, 0 input, resets 0.
// - second port output latch readable, writable, resets 0, drives output pins.
// - first port pin-level read returns the pins, never the latch.
// - second port pin-level read returns the current eight pin levels.
`timescale 1ns/1ns

module pabc_pins (
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pce,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// system state
	input  wire logic        hw_standby,
	input  wire logic        sw_standby,
	input  wire logic [7:0]  bus_address_high,
	// first port pins
	input  wire logic [7:0]  pa_in,
	output logic      [7:0]  pa_out,
	output logic      [7:0]  pa_oe,
	output logic      [7:0]  pa_pullup,
	// second port pins
	input  wire logic [7:0]  pb_in,
	output logic      [7:0]  pb_out,
	output logic      [7:0]  pb_oe,
	// peripheral inputs taken from the pins
	output logic      [7:0]  keyboard_wake_n,
	output logic             event_count_in,
	output logic             serial0_ext_clock_in,
	output logic             serial2_ext_clock_in
);

	// map a byte address to a register index; shared by read and write paths
	function automatic pabc_pkg::pabc_reg_t decode(input logic [7:0] addr);
		unique case (addr)
			pabc_pkg::OFS_A_DIR:   decode = pabc_pkg::REG_A_DIR;
			pabc_pkg::OFS_A_LATCH: decode = pabc_pkg::REG_A_LATCH;
			pabc_pkg::OFS_B_DIR:   decode = pabc_pkg::REG_B_DIR;
			pabc_pkg::OFS_B_LATCH: decode = pabc_pkg::REG_B_LATCH;
			pabc_pkg::OFS_MODE:    decode = pabc_pkg::REG_MODE;
			pabc_pkg::OFS_PERIPH:  decode = pabc_pkg::REG_PERIPH;
			pabc_pkg::OFS_STATUS:  decode = pabc_pkg::REG_STATUS;
			default:               decode = pabc_pkg::REG_NONE;
		endcase
	endfunction : decode

	// merge a write under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
	                                      input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = wd[8*i +: 8];
			end
		end
		merge = res;
	endfunction : merge

	// pin synchronisers: stage one is read only by stage two
	logic [7:0]  pa_meta;
	logic [7:0]  pa_sync;
	logic [7:0]  pb_meta;
	logic [7:0]  pb_sync;

	// register state
	logic [7:0]  a_dir;
	logic [7:0]  a_latch;
	logic [7:0]  b_dir;
	logic [7:0]  b_latch;
	logic [31:0] mode_reg;
	logic [31:0] periph_reg;
	logic [7:0]  pu_held;
	logic [31:0] rdata_q;
	logic [7:0]  next_a_dir;
	logic [7:0]  next_a_latch;
	logic [7:0]  next_b_dir;
	logic [7:0]  next_b_latch;
	logic [31:0] next_mode_reg;
	logic [31:0] next_periph_reg;
	logic [7:0]  next_pu_held;
	logic [31:0] next_rdata_q;

	// decoded control
	pabc_pkg::pabc_mode_t mode;
	pabc_pkg::pabc_reg_t  sel_reg;
	logic        normal_ext;
	logic        addr13_sig;
	logic        addr18_sig;
	logic        s0_clk_sel;
	logic        s2_clk_sel;
	logic [7:0]  kmask;
	logic [3:0]  ev_sel;
	logic [7:0]  pu_live;
	logic        wr_en;
	logic        setup;

	// two flops on every pin input before any logic sees it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_meta <= pabc_pkg::PORT_RESET;
			pa_sync <= pabc_pkg::PORT_RESET;
			pb_meta <= pabc_pkg::PORT_RESET;
			pb_sync <= pabc_pkg::PORT_RESET;
		end else if (pce) begin
			pa_meta <= pa_in;
			pa_sync <= pa_meta;
			pb_meta <= pb_in;
			pb_sync <= pb_meta;
		end
	end

	// control field decode; an illegal mode code falls back to single-chip
	always_comb begin
		unique case (mode_reg[pabc_pkg::MODE_LSB +: pabc_pkg::MODE_W])
			3'b001:  mode = pabc_pkg::MODE_SINGLE;
			3'b010:  mode = pabc_pkg::MODE_MUX;
			3'b100:  mode = pabc_pkg::MODE_NORMAL;
			default: mode = pabc_pkg::MODE_SINGLE;
		endcase
	end

	assign normal_ext = (mode == pabc_pkg::MODE_NORMAL);
	assign addr13_sig = mode_reg[pabc_pkg::ADDR13_BIT];
	assign addr18_sig = mode_reg[pabc_pkg::ADDR18_BIT];
	assign kmask      = periph_reg[pabc_pkg::KMASK_LSB +: pabc_pkg::PORT_W];
	assign ev_sel     = periph_reg[pabc_pkg::EVSEL_LSB +: pabc_pkg::EVSEL_W];
	// serial clock pick-up needs all three channel bits, in every mode
	assign s0_clk_sel = periph_reg[pabc_pkg::S0_EXT_BIT] & periph_reg[pabc_pkg::S0_SYNC_BIT]
	                  & periph_reg[pabc_pkg::S0_CLKIN_BIT];
	assign s2_clk_sel = periph_reg[pabc_pkg::S2_EXT_BIT] & periph_reg[pabc_pkg::S2_SYNC_BIT]
	                  & periph_reg[pabc_pkg::S2_CLKIN_BIT];

	// first port per-pin function select
	genvar n;
	generate
		for (n = 0; n < 8; n++) begin : g_pa
			logic ext_clk;
			logic addr_drv;
			// only pins 0 and 1 can be taken by a serial clock
			assign ext_clk  = (n == 0) ? s0_clk_sel : ((n == 1) ? s2_clk_sel : 1'b0);
			// address bits appear only in normal extended mode, direction 1, width signal 0
			assign addr_drv = normal_ext & a_dir[n]
			                & ~((n < 2) ? addr13_sig : addr18_sig);
			// direction 1 drives even when the event counter selected this pin
			assign pa_oe[n]  = a_dir[n] & ~ext_clk;
			assign pa_out[n] = addr_drv ? bus_address_high[n] : a_latch[n];
			// keyboard wakeup is active low; masked or driven pins read inactive
			assign keyboard_wake_n[n] = (kmask[n] | a_dir[n]) ? 1'b1 : pa_sync[n];
			assign pu_live[n] = ~a_dir[n] & a_latch[n];
		end
	endgenerate

	// serial clocks are passed only while their channel claims the pin
	assign serial0_ext_clock_in = s0_clk_sel & pa_sync[0];
	assign serial2_ext_clock_in = s2_clk_sel & pa_sync[1];

	// event counter source: codes 0..7 first port, 8..15 second port
	assign event_count_in = ev_sel[3] ? pb_sync[ev_sel[2:0]] : pa_sync[ev_sel[2:0]];

	// second port drives its latch wherever direction is 1
	assign pb_oe  = b_dir;
	assign pb_out = b_latch;

	// pull-ups: forced off in hardware standby, frozen in software standby;
	// reset clears both latches so the live term is off too
	assign pa_pullup = hw_standby ? pabc_pkg::PORT_RESET
	                 : (sw_standby ? pu_held : pu_live);

	// apb: zero wait states, read data captured in the setup cycle
	assign setup   = psel & ~penable;
	assign sel_reg = decode(paddr);
	assign wr_en   = psel & penable & pwrite & (sel_reg != pabc_pkg::REG_NONE)
	               & (sel_reg != pabc_pkg::REG_STATUS);
	assign pready  = 1'b1;
	// unmapped offsets and writes to the status word are refused
	assign pslverr = psel & penable & ((sel_reg == pabc_pkg::REG_NONE)
	               | (pwrite & (sel_reg == pabc_pkg::REG_STATUS)));
	assign prdata  = rdata_q;

	// next register values
	always_comb begin
		next_a_dir      = a_dir;
		next_a_latch    = a_latch;
		next_b_dir      = b_dir;
		next_b_latch    = b_latch;
		next_mode_reg   = mode_reg;
		next_periph_reg = periph_reg;
		next_rdata_q    = rdata_q;
		// held copy tracks the live value until software standby begins
		next_pu_held    = sw_standby ? pu_held : pu_live;
		if (hw_standby) begin
			next_pu_held = pabc_pkg::PORT_RESET;
		end
		if (wr_en && pstrb[0]) begin
			unique case (sel_reg)
				pabc_pkg::REG_A_DIR:   next_a_dir   = pwdata[7:0];
				pabc_pkg::REG_A_LATCH: next_a_latch = pwdata[7:0];
				pabc_pkg::REG_B_DIR:   next_b_dir   = pwdata[7:0];
				pabc_pkg::REG_B_LATCH: next_b_latch = pwdata[7:0];
				default: begin
				end
			endcase
		end
		if (wr_en && sel_reg == pabc_pkg::REG_MODE) begin
			next_mode_reg = merge(mode_reg, pwdata, pstrb);
		end
		if (wr_en && sel_reg == pabc_pkg::REG_PERIPH) begin
			next_periph_reg = merge(periph_reg, pwdata, pstrb);
		end
		if (setup) begin
			next_rdata_q = 32'h0000_0000;
			unique case (sel_reg)
				// direction words are write only; their address reads the pins
				pabc_pkg::REG_A_DIR:   next_rdata_q[7:0] = pa_sync;
				pabc_pkg::REG_A_LATCH: next_rdata_q[7:0] = a_latch;
				pabc_pkg::REG_B_DIR:   next_rdata_q[7:0] = pb_sync;
				pabc_pkg::REG_B_LATCH: next_rdata_q[7:0] = b_latch;
				pabc_pkg::REG_MODE:    next_rdata_q = mode_reg;
				pabc_pkg::REG_PERIPH:  next_rdata_q = periph_reg;
				pabc_pkg::REG_STATUS: begin
					next_rdata_q[pabc_pkg::STAT_PU_LSB +: 8]  = pa_pullup;
					next_rdata_q[pabc_pkg::STAT_AOE_LSB +: 8] = pa_oe;
					next_rdata_q[pabc_pkg::STAT_BOE_LSB +: 8] = pb_oe;
				end
				default: begin
				end
			endcase
		end
	end

	// register update; pce low freezes everything
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_dir      <= pabc_pkg::PORT_RESET;
			a_latch    <= pabc_pkg::PORT_RESET;
			b_dir      <= pabc_pkg::PORT_RESET;
			b_latch    <= pabc_pkg::PORT_RESET;
			mode_reg   <= pabc_pkg::MODE_RESET;
			periph_reg <= pabc_pkg::PERIPH_RESET;
			pu_held    <= pabc_pkg::PORT_RESET;
			rdata_q    <= 32'h0000_0000;
		end else if (pce) begin
			a_dir      <= next_a_dir;
			a_latch    <= next_a_latch;
			b_dir      <= next_b_dir;
			b_latch    <= next_b_latch;
			mode_reg   <= next_mode_reg;
			periph_reg <= next_periph_reg;
			pu_held    <= next_pu_held;
			rdata_q    <= next_rdata_q;
		end
	end

endmodule : pabc_pins

/* sim/pabc_pins_checker.sv */
// pabc_pins_checker: port-level assertions for the two-port pin control block.
// assumes a zero-wait apb slave whose writes land at the access edge.
`timescale 1ns/1ns

module pabc_pins_checker (
	// clock, reset, enable
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        pce,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	// system state
	input wire logic        hw_standby,
	input wire logic        sw_standby,
	// pins
	input wire logic [7:0]  pa_oe,
	input wire logic [7:0]  pa_pullup,
	input wire logic [7:0]  pb_out,
	input wire logic [7:0]  pb_oe,
	input wire logic [7:0]  keyboard_wake_n,
	input wire logic        serial0_ext_clock_in,
	input wire logic        serial2_ext_clock_in
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// a write access to one register, low byte enabled
	sequence wr_acc(logic [7:0] a);
		psel && penable && pwrite && pce && pstrb[0] && paddr == a;
	endsequence

	pb_dir_a: assert property (wr_acc(pabc_pkg::OFS_B_DIR) |=> pb_oe == $past(pwdata[7:0]))
		else $error("second port enables do not follow write");
	pb_lat_a: assert property (wr_acc(pabc_pkg::OFS_B_LATCH) |=> pb_out == $past(pwdata[7:0]))
		else $error("second port drive does not follow write");
	// standby may legally hold a pull-up whose latch bit was cleared
	pa_lat_a: assert property (wr_acc(pabc_pkg::OFS_A_LATCH) ##1 !sw_standby |->
		(pa_pullup & ~$past(pwdata[7:0])) == 8'h00) else $error("pull-up on with latch bit 0");
	pull_drv_a: assert property (!sw_standby |-> (pa_pullup & pa_oe) == 8'h00)
		else $error("pull-up on a driven pin");
	hw_pull_a: assert property (hw_standby [*2] |-> pa_pullup == 8'h00)
		else $error("pull-up on in hardware standby");
	sw_hold_a: assert property ((sw_standby && !hw_standby) [*2] |-> $stable(pa_pullup))
		else $error("pull-up changed in software standby");
	s0_claim_a: assert property (serial0_ext_clock_in |-> !pa_oe[0])
		else $error("pin 0 driven while serial clock input");
	s2_claim_a: assert property (serial2_ext_clock_in |-> !pa_oe[1])
		else $error("pin 1 driven while serial clock input");
	kb_in_a: assert property ((~keyboard_wake_n[1:0] & pa_oe[1:0]) == 2'b00)
		else $error("wakeup input taken from driven pin");
	rd_lat_a: assert property (psel && penable && !pwrite && paddr == pabc_pkg::OFS_B_LATCH
		&& $stable(pb_out) |-> prdata == {24'h000000, pb_out}) else $error("latch read wrong");
endmodule : pabc_pins_checker

/* sim/pabc_pin_model.sv */
// pabc_pin_model: the package pins of both ports with an external driver behind them.
// assumes undriven pins without pull-up follow the external level given by the bench.
`timescale 1ns/1ns

module pabc_pin_model (
	// block side
	input  wire logic [7:0] pa_out,
	input  wire logic [7:0] pa_oe,
	input  wire logic [7:0] pa_pullup,
	input  wire logic [7:0] pb_out,
	input  wire logic [7:0] pb_oe,
	// external levels
	input  wire logic [7:0] ext_a,
	input  wire logic [7:0] ext_b,
	// pin levels seen by the block
	output logic      [7:0] pa_in,
	output logic      [7:0] pb_in
);
	// a weak pull-up loses to the driver, so it only shows on released pins
	assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_pullup) | (~pa_oe & ~pa_pullup & ext_a);
	assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
endmodule : pabc_pin_model

/* sim/pabc_pins_tb.sv */
// pabc_pins_tb: register-level tests of the pin control block through apb.
// assumes the pin model resolves both ports; pce and all byte strobes stay high.
`timescale 1ns/1ns

module pabc_pins_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        hw_standby, sw_standby, event_count_in, serial0_ext_clock_in, serial2_ext_clock_in;
	logic [7:0]  paddr, bus_address_high, ext_a, ext_b, pa_in, pa_out, pa_oe, pa_pullup;
	logic [7:0]  pb_in, pb_out, pb_oe, keyboard_wake_n;
	logic [31:0] pwdata, prdata, rd;
	int          n_mismatch, comparisons;

	pabc_pins i_pabc_pins (.pce(1'b1), .pstrb(4'hF), .*);
	pabc_pin_model i_pabc_pin_model (.*);

	// free-running 50 MHz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run

	// one transfer; the request is held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			n_mismatch++;
			complete_run();
		end
	endtask : apb

	// pins are synced over two flops, so level checks wait a few edges
	task wt(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : wt

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, hw_standby, sw_standby} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		bus_address_high = 8'h5A;
		ext_a = 8'h40;
		ext_b = 8'hC3;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		wt(1);
		chk(pa_pullup, 8'h00);
		chk(pb_oe, 8'h00);
		apb(1'b0, pabc_pkg::OFS_B_LATCH, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, pabc_pkg::OFS_B_DIR, 32'hA5);
		apb(1'b1, pabc_pkg::OFS_B_LATCH, 32'h3C);
		wt(1);
		chk(pb_oe, 8'hA5);
		chk(pb_out, 8'h3C);
		apb(1'b0, pabc_pkg::OFS_B_DIR, 32'h0);
		chk(rd, 32'h66);
		$display("second port test done");
		apb(1'b1, pabc_pkg::OFS_A_DIR, 32'h0F);
		apb(1'b1, pabc_pkg::OFS_A_LATCH, 32'h33);
		wt(1);
		chk(pa_pullup, 8'h30);
		apb(1'b0, pabc_pkg::OFS_A_DIR, 32'h0);
		chk(rd, 32'h73);
		@(posedge pclk);
		sw_standby <= 1'b1;
		apb(1'b1, pabc_pkg::OFS_A_LATCH, 32'h01);
		wt(1);
		chk(pa_pullup, 8'h30);
		@(posedge pclk);
		hw_standby <= 1'b1;
		wt(2);
		chk(pa_pullup, 8'h00);
		@(posedge pclk);
		hw_standby <= 1'b0;
		sw_standby <= 1'b0;
		ext_a <= 8'h41;
		$display("pull-up test done");
		apb(1'b1, pabc_pkg::OFS_PERIPH, 32'hFF3F);
		wt(4);
		chk(pa_oe, 8'h0C);
		chk(serial0_ext_clock_in, 1'b1);
		chk(serial2_ext_clock_in, 1'b0);
		apb(1'b1, pabc_pkg::OFS_PERIPH, 32'hFF00);
		wt(4);
		chk(pa_oe[0], 1'b1);
		chk(event_count_in, 1'b1);
		apb(1'b1, pabc_pkg::OFS_MODE, 32'h14);
		wt(1);
		chk(pa_out & pa_oe, 8'h02);
		for (int m = 1; m < 3; m++) begin
			apb(1'b1, pabc_pkg::OFS_MODE, m);
			wt(1);
			chk(pa_out & pa_oe, 8'h01);
		end
		$display("pin function test done");
		apb(1'b1, pabc_pkg::OFS_A_DIR, 32'h0C);
		apb(1'b1, pabc_pkg::OFS_PERIPH, 32'hFC00);
		wt(4);
		chk(keyboard_wake_n, 8'hFD);
		apb(1'b0, 8'h1C, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		chk(pready, 1'b1);
		// event codes 8..15 pick the second port; pin b1 is high, pin a1 low
		apb(1'b1, pabc_pkg::OFS_PERIPH, 32'h0009FC00);
		wt(1);
		chk(event_count_in, 1'b1);
		// status word: pull-ups, first port enables, second port enables
		apb(1'b0, pabc_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'h00A50C01);
		$display("wakeup and decode test done");
		// reset in mid-run: pull-up must drop while reset is held
		@(posedge pclk);
		presetn <= 1'b0;
		wt(1);
		chk(pa_pullup, 8'h00);
		@(posedge pclk);
		presetn <= 1'b1;
		wt(2);
		chk(pb_oe, 8'h00);
		chk(pb_out, 8'h00);
		$display("reset test done");
		complete_run();
	end
endmodule : pabc_pins_tb

bind pabc_pins pabc_pins_checker i_pabc_pins_checker (.*);
